// ===== logic/iwd_consts.vh
// Constants for the instruction word decoder: field positions, encodings, reset values.
// Assumes inclusion by bare name from the decoder files.
`ifndef IWD_CONSTS_VH
`define IWD_CONSTS_VH
`define IWD_WORD_W 14
`define IWD_CLASS_HI 13
`define IWD_CLASS_LO 12
`define IWD_OP4_HI 11
`define IWD_OP4_LO 8
`define IWD_DEST_BIT 7
`define IWD_FILE_HI 6
`define IWD_FILE_LO 0
`define IWD_BIT_HI 9
`define IWD_BIT_LO 7
`define IWD_K8_HI 7
`define IWD_K11_HI 10
`define IWD_CALL_BIT 11
`define IWD_CLASS_BYTE 2'b00
`define IWD_CLASS_BIT 2'b01
`define IWD_CLASS_JUMP 2'b10
`define IWD_CLASS_LIT 2'b11
`define IWD_IDLE_WORD 14'h0000
`define IWD_RETURN_LOW 8'h08
`define IWD_RESET_PC 13'h0000
`define IWD_RESET_W 8'h00
`define IWD_RESET_SP 3'h0
`define IWD_FILE_FIRST 7'h00
`define IWD_FILE_LAST 7'h7F
`define IWD_Q_PER_CYCLE 4
`endif

// ===== logic/iwd_file_ram.v
// File register memory with a registered read port.
// Assumes one clock; write takes effect at the edge, read data appear one edge later.
module iwd_file_ram #(
  parameter ADDR_W = 7,
  parameter DATA_W = 8
) (
  input wire clk,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [DATA_W-1:0] rd_data
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== logic/iwd_core.v
// Instruction word decoder and sequencer of a small 8-bit core.
// Assumes program memory on mclk answers prog_addr with prog_word by the fourth phase.
//
// Notes on behaviour
// - Each instruction is one 14-bit word
// - Byte, bit and literal/control categories decoded
// - Destination bit zero to accumulator, one to file
// - File address field spans 0x00 to 0x7F
// - Bit selector picks one of eight bits
// - Literals are 8 or 11 bits wide
// - Four clock phases form one instruction cycle
// - Taken test or branch adds idle cycle
// - File operand always read and modified, stored only for file destination or bit set/clear
// - Don't-care bits never change decoding
`include "iwd_consts.vh"
module iwd_core #(
  parameter PC_W = 13,
  parameter FILE_AW = 7,
  parameter SP_W = 3
) (
  input wire mclk,
  input wire rst_b,
  input wire [`IWD_WORD_W-1:0] prog_word,
  output reg [PC_W-1:0] prog_addr,
  output reg [`IWD_WORD_W-1:0] exec_word,
  output reg [1:0] instr_class,
  output reg [3:0] q_phase,
  output reg idle_slot,
  output reg retire,
  output reg [7:0] accum,
  output reg flag_c,
  output reg flag_dc,
  output reg flag_z,
  output reg file_wr,
  output reg [FILE_AW-1:0] file_addr,
  output reg [7:0] file_wdata
);
  localparam Q1 = 4'b0001;
  localparam Q2 = 4'b0010;
  localparam Q3 = 4'b0100;
  localparam Q4 = 4'b1000;
  localparam STACK_D = 1 << SP_W;

  localparam OP_MOVWF = 4'h0;
  localparam OP_CLR = 4'h1;
  localparam OP_SUBWF = 4'h2;
  localparam OP_DECF = 4'h3;
  localparam OP_IORWF = 4'h4;
  localparam OP_ANDWF = 4'h5;
  localparam OP_XORWF = 4'h6;
  localparam OP_ADDWF = 4'h7;
  localparam OP_MOVF = 4'h8;
  localparam OP_COMF = 4'h9;
  localparam OP_INCF = 4'hA;
  localparam OP_DECFSZ = 4'hB;
  localparam OP_RRF = 4'hC;
  localparam OP_RLF = 4'hD;
  localparam OP_SWAPF = 4'hE;
  localparam OP_INCFSZ = 4'hF;

  localparam BOP_CLEAR = 2'b00;
  localparam BOP_SET = 2'b01;
  localparam BOP_TEST_CLR = 2'b10;
  localparam BOP_TEST_SET = 2'b11;

  // Category from the top two bits
  function [1:0] iwd_class;
    input [`IWD_WORD_W-1:0] word;
    begin
      iwd_class = word[`IWD_CLASS_HI:`IWD_CLASS_LO];
    end
  endfunction

  // One-hot mask of the selected bit
  function [7:0] iwd_bit_mask;
    input [2:0] sel;
    integer i;
    begin
      iwd_bit_mask = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        if (sel == i[2:0]) begin
          iwd_bit_mask[i] = 1'b1;
        end
      end
    end
  endfunction

  reg [`IWD_WORD_W-1:0] ir;
  reg [PC_W-1:0] pc;
  reg [7:0] opnd;
  reg [7:0] res;
  reg to_w;
  reg take;
  reg push;
  reg pop;
  reg jump;
  reg pend_c;
  reg pend_dc;
  reg pend_z;
  reg [SP_W-1:0] sp;
  reg [PC_W-1:0] stack [0:STACK_D-1];

  reg [7:0] next_res;
  reg next_c;
  reg next_dc;
  reg next_z;
  reg next_to_w;
  reg next_to_f;
  reg next_take;
  reg next_push;
  reg next_pop;
  reg next_jump;
  reg aff_z;
  reg [7:0] add_a;
  reg [7:0] add_b;
  reg add_cin;

  wire [7:0] rd_data;
  wire [3:0] op4 = ir[`IWD_OP4_HI:`IWD_OP4_LO];
  wire dest = ir[`IWD_DEST_BIT];
  wire [FILE_AW-1:0] faddr = ir[`IWD_FILE_HI:`IWD_FILE_LO];
  wire [7:0] k8 = ir[`IWD_K8_HI:0];
  wire [`IWD_K11_HI:0] k11 = ir[`IWD_K11_HI:0];
  wire [7:0] bmask = iwd_bit_mask(ir[`IWD_BIT_HI:`IWD_BIT_LO]);
  wire is_sub = ((iwd_class(ir) == `IWD_CLASS_BYTE) && (op4 == OP_SUBWF)) ||
                ((iwd_class(ir) == `IWD_CLASS_LIT) && (op4[3:1] == 3'b110));
  wire [8:0] sum9 = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
  wire [4:0] nib5 = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  wire [SP_W-1:0] sp_top = sp - {{(SP_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};
  wire [`IWD_WORD_W-1:0] next_ir = take ? `IWD_IDLE_WORD : prog_word;

  // File registers, read every cycle at the decoded address
  iwd_file_ram #(
    .ADDR_W(FILE_AW),
    .DATA_W(8)
  ) u_file_ram (
    .clk(mclk),
    .wr_en(file_wr),
    .wr_addr(file_addr),
    .wr_data(file_wdata),
    .rd_addr(faddr),
    .rd_data(rd_data)
  );

  // Phase ring, one instruction cycle per turn
  always @(posedge mclk) begin
    if (!rst_b) begin
      q_phase <= Q1;
    end else begin
      case (q_phase)
        Q1: q_phase <= Q2;
        Q2: q_phase <= Q3;
        Q3: q_phase <= Q4;
        Q4: q_phase <= Q1;
        default: q_phase <= Q1;
      endcase
    end
  end

  // Adder operands
  always @* begin
    add_a = opnd;
    add_b = accum;
    add_cin = 1'b0;
    if (iwd_class(ir) == `IWD_CLASS_LIT) begin
      add_a = k8;
    end
    if (is_sub) begin
      add_b = ~accum;
      add_cin = 1'b1;
    end
  end

  // Decode and execute
  always @* begin
    next_res = opnd;
    next_c = flag_c;
    next_dc = flag_dc;
    next_z = flag_z;
    next_to_w = 1'b0;
    next_to_f = 1'b0;
    next_take = 1'b0;
    next_push = 1'b0;
    next_pop = 1'b0;
    next_jump = 1'b0;
    aff_z = 1'b0;
    case (iwd_class(ir))
      `IWD_CLASS_BYTE: begin
        next_to_w = ~dest;
        next_to_f = dest;
        case (op4)
          OP_MOVWF: begin
            next_res = accum;
            next_to_w = 1'b0;
            if (!dest && ir[7:0] == `IWD_RETURN_LOW) begin
              next_pop = 1'b1;
              next_take = 1'b1;
            end
          end
          OP_CLR: begin
            next_res = 8'h00;
            aff_z = 1'b1;
          end
          OP_SUBWF, OP_ADDWF: begin
            next_res = sum9[7:0];
            next_c = sum9[8];
            next_dc = nib5[4];
            aff_z = 1'b1;
          end
          OP_DECF: begin
            next_res = opnd - 8'h01;
            aff_z = 1'b1;
          end
          OP_IORWF: begin
            next_res = accum | opnd;
            aff_z = 1'b1;
          end
          OP_ANDWF: begin
            next_res = accum & opnd;
            aff_z = 1'b1;
          end
          OP_XORWF: begin
            next_res = accum ^ opnd;
            aff_z = 1'b1;
          end
          OP_MOVF: begin
            next_res = opnd;
            aff_z = 1'b1;
          end
          OP_COMF: begin
            next_res = ~opnd;
            aff_z = 1'b1;
          end
          OP_INCF: begin
            next_res = opnd + 8'h01;
            aff_z = 1'b1;
          end
          OP_DECFSZ: begin
            next_res = opnd - 8'h01;
            next_take = (opnd == 8'h01);
          end
          OP_RRF: begin
            next_res = {flag_c, opnd[7:1]};
            next_c = opnd[0];
          end
          OP_RLF: begin
            next_res = {opnd[6:0], flag_c};
            next_c = opnd[7];
          end
          OP_SWAPF: begin
            next_res = {opnd[3:0], opnd[7:4]};
          end
          OP_INCFSZ: begin
            next_res = opnd + 8'h01;
            next_take = (opnd == 8'hFF);
          end
          default: begin
            next_res = opnd;
          end
        endcase
      end
      `IWD_CLASS_BIT: begin
        case (ir[11:10])
          BOP_CLEAR: begin
            next_res = opnd & ~bmask;
            next_to_f = 1'b1;
          end
          BOP_SET: begin
            next_res = opnd | bmask;
            next_to_f = 1'b1;
          end
          BOP_TEST_CLR: begin
            next_take = ((opnd & bmask) == 8'h00);
          end
          BOP_TEST_SET: begin
            next_take = ((opnd & bmask) != 8'h00);
          end
          default: begin
            next_take = 1'b0;
          end
        endcase
      end
      `IWD_CLASS_JUMP: begin
        next_jump = 1'b1;
        next_take = 1'b1;
        next_push = ~ir[`IWD_CALL_BIT];
      end
      default: begin
        next_res = k8;
        casez (op4)
          4'b00??: begin
            next_to_w = 1'b1;
          end
          4'b01??: begin
            next_to_w = 1'b1;
            next_pop = 1'b1;
            next_take = 1'b1;
          end
          4'b1000: begin
            next_res = accum | k8;
            next_to_w = 1'b1;
            aff_z = 1'b1;
          end
          4'b1001: begin
            next_res = accum & k8;
            next_to_w = 1'b1;
            aff_z = 1'b1;
          end
          4'b1010: begin
            next_res = accum ^ k8;
            next_to_w = 1'b1;
            aff_z = 1'b1;
          end
          4'b11??: begin
            next_res = sum9[7:0];
            next_c = sum9[8];
            next_dc = nib5[4];
            next_to_w = 1'b1;
            aff_z = 1'b1;
          end
          default: begin
            next_res = k8;
          end
        endcase
      end
    endcase
    if (aff_z) begin
      next_z = (next_res == 8'h00);
    end
  end

  // Read in Q2, modify in Q3, store and advance in Q4
  always @(posedge mclk) begin
    if (!rst_b) begin
      ir <= `IWD_IDLE_WORD;
      exec_word <= `IWD_IDLE_WORD;
      instr_class <= `IWD_CLASS_BYTE;
      pc <= `IWD_RESET_PC;
      prog_addr <= `IWD_RESET_PC;
      idle_slot <= 1'b1;
      retire <= 1'b0;
      accum <= `IWD_RESET_W;
      flag_c <= 1'b0;
      flag_dc <= 1'b0;
      flag_z <= 1'b0;
      file_wr <= 1'b0;
      file_addr <= `IWD_FILE_FIRST;
      file_wdata <= 8'h00;
      opnd <= 8'h00;
      res <= 8'h00;
      to_w <= 1'b0;
      take <= 1'b0;
      push <= 1'b0;
      pop <= 1'b0;
      jump <= 1'b0;
      pend_c <= 1'b0;
      pend_dc <= 1'b0;
      pend_z <= 1'b0;
      sp <= `IWD_RESET_SP;
    end else begin
      retire <= 1'b0;
      file_wr <= 1'b0;
      if (q_phase == Q2) begin
        opnd <= rd_data;
      end
      if (q_phase == Q3) begin
        res <= next_res;
        to_w <= next_to_w;
        take <= next_take;
        push <= next_push;
        pop <= next_pop;
        jump <= next_jump;
        pend_c <= next_c;
        pend_dc <= next_dc;
        pend_z <= next_z;
        file_wr <= next_to_f;
        file_addr <= faddr;
        file_wdata <= next_res;
        retire <= 1'b1;
      end
      if (q_phase == Q4) begin
        if (to_w) begin
          accum <= res;
        end
        flag_c <= pend_c;
        flag_dc <= pend_dc;
        flag_z <= pend_z;
        ir <= next_ir;
        exec_word <= next_ir;
        instr_class <= iwd_class(next_ir);
        idle_slot <= take;
        if (jump) begin
          pc <= {pc[PC_W-1:`IWD_K11_HI+1], k11};
          prog_addr <= {pc[PC_W-1:`IWD_K11_HI+1], k11};
        end else if (pop) begin
          pc <= stack[sp_top];
          prog_addr <= stack[sp_top];
        end else begin
          pc <= pc_inc;
          prog_addr <= pc_inc;
        end
        if (push) begin
          stack[sp] <= pc;
          sp <= sp + {{(SP_W-1){1'b0}}, 1'b1};
        end else if (pop) begin
          sp <= sp_top;
        end
      end
    end
  end
endmodule

// ===== verification/iwd_core_assertions.sv
// Checker of the instruction word decoder, watching its ports only.
// Assumes binding onto iwd_core, one clock mclk, synchronous rst_b.
module iwd_core_assertions #(
  parameter PC_W = 13,
  parameter FILE_AW = 7
) (
  input wire mclk,
  input wire rst_b,
  input wire [PC_W-1:0] prog_addr,
  input wire [13:0] exec_word,
  input wire [1:0] instr_class,
  input wire [3:0] q_phase,
  input wire idle_slot,
  input wire retire,
  input wire file_wr,
  input wire [FILE_AW-1:0] file_addr
);
  wire [10:0] jump_k = exec_word[10:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_phases;
    q_phase == 4'b0001 ##1 q_phase == 4'b0010 ##1 q_phase == 4'b0100 ##1 q_phase == 4'b1000;
  endsequence
  sequence s_idle_cycle;
    (idle_slot && exec_word == 14'h0000) [*4];
  endsequence
  sequence s_jump_q4;
    exec_word[13:12] == 2'b10 && retire;
  endsequence
  AST_Q_ROTATE: assert property (q_phase == 4'b0001 |-> s_phases)
    else $error("phase rotation broken");
  AST_RETIRE_Q4: assert property (retire == (q_phase == 4'b1000))
    else $error("retire not in fourth phase");
  AST_ADDR_HOLD: assert property (q_phase != 4'b0001 |-> $stable(prog_addr))
    else $error("fetch address moved inside a cycle");
  AST_JUMP_IDLE: assert property (s_jump_q4 |=> s_idle_cycle)
    else $error("no idle cycle after jump");
  AST_JUMP_TARGET: assert property (s_jump_q4 |=> prog_addr[10:0] == $past(jump_k))
    else $error("jump target wrong");
  AST_CLASS: assert property (instr_class == exec_word[13:12])
    else $error("class does not match word");
  AST_STORE_ADDR: assert property (file_wr |-> retire && file_addr == exec_word[6:0])
    else $error("store address or moment wrong");
  AST_DEST_W: assert property (exec_word[13:12] == 2'b00 && !exec_word[7] |-> !file_wr)
    else $error("store with accumulator destination");
  AST_DEST_F: assert property (retire && exec_word[13:12] == 2'b00 && exec_word[7] |-> file_wr)
    else $error("missing store with file destination");
  AST_LIT_NO_STORE: assert property (exec_word[13] |-> !file_wr)
    else $error("store from literal or jump");
  AST_TEST_NO_STORE: assert property (exec_word[13:11] == 3'b011 |-> !file_wr)
    else $error("store from bit test");
endmodule

// ===== verification/iwd_prog_mem.sv
// Program memory model answering each fetch address one clock later.
// Assumes the bench loads mem before reset is released.
module iwd_prog_mem (
  input wire mclk,
  input wire [12:0] prog_addr,
  output logic [13:0] prog_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [0:15];
  initial prog_word = 14'h0000;
  always @(posedge mclk) begin
    prog_word <= mem[prog_addr[3:0]];
  end
endmodule

// ===== verification/tb_instruction_word_decoder.sv
// Testbench of the instruction word decoder, driven through program memory.
// Assumes iwd_core, iwd_prog_mem and the checker are compiled first.
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h seen %h", n, e, g); end end
module tb_instruction_word_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic rst_b;
  wire [13:0] prog_word;
  wire [12:0] prog_addr;
  wire [13:0] exec_word;
  wire [1:0] instr_class;
  wire [3:0] q_phase;
  wire idle_slot;
  wire retire;
  wire [7:0] accum;
  wire flag_c;
  wire flag_dc;
  wire flag_z;
  wire file_wr;
  wire [6:0] file_addr;
  wire [7:0] file_wdata;
  int err_count = 0;
  int compares = 0;
  logic [13:0] prog_image [13] = '{14'h305A, 14'h00A0, 14'h0720, 14'h07A0, 14'h17A0, 14'h1FA0,
    14'h30FF, 14'h0100, 14'h3033, 14'h017F, 14'h280C, 14'h30FF, 14'h280C};
  iwd_core u_iwd_core (.mclk(mclk), .rst_b(rst_b), .prog_word(prog_word), .prog_addr(prog_addr),
    .exec_word(exec_word), .instr_class(instr_class), .q_phase(q_phase), .idle_slot(idle_slot),
    .retire(retire), .accum(accum), .flag_c(flag_c), .flag_dc(flag_dc), .flag_z(flag_z),
    .file_wr(file_wr), .file_addr(file_addr), .file_wdata(file_wdata));
  iwd_prog_mem u_iwd_prog_mem (.mclk(mclk), .prog_addr(prog_addr), .prog_word(prog_word));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic next_q4;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (retire !== 1'b1 && n < 8);
  endtask
  task automatic check_cycle(input logic [13:0] w, input logic [1:0] c, input logic idl, input logic wr,
    input logic [7:0] d);
    next_q4();
    `CHK("exec_word", w, exec_word)
    `CHK("instr_class", c, instr_class)
    `CHK("idle_slot", idl, idle_slot)
    `CHK("file_wr", wr, file_wr)
    if (wr) begin
      `CHK("file_addr", 7'h20, file_addr)
      `CHK("file_wdata", d, file_wdata)
    end
  endtask
  task automatic test_reset;
    repeat (10) @(posedge mclk);
    #1;
    `CHK("q_phase", 4'h1, q_phase)
    `CHK("accum", 8'h00, accum)
    @(posedge mclk);
    rst_b <= 1'b1;
    check_cycle(14'h0000, 2'b00, 1'b1, 1'b0, 8'h00);
    $display("test_reset done");
  endtask
  task automatic test_byte_ops;
    check_cycle(14'h305A, 2'b11, 1'b0, 1'b0, 8'h00);
    check_cycle(14'h00A0, 2'b00, 1'b0, 1'b1, 8'h5A);
    `CHK("accum", 8'h5A, accum)
    check_cycle(14'h0720, 2'b00, 1'b0, 1'b0, 8'h00);
    check_cycle(14'h07A0, 2'b00, 1'b0, 1'b1, 8'h0E);
    `CHK("accum", 8'hB4, accum)
    `CHK("flag_dc", 1'b1, flag_dc)
    $display("test_byte_ops done");
  endtask
  task automatic test_bit_skip;
    check_cycle(14'h17A0, 2'b01, 1'b0, 1'b1, 8'h8E);
    `CHK("flag_c", 1'b1, flag_c)
    check_cycle(14'h1FA0, 2'b01, 1'b0, 1'b0, 8'h00);
    check_cycle(14'h0000, 2'b00, 1'b1, 1'b0, 8'h00);
    check_cycle(14'h0100, 2'b00, 1'b0, 1'b0, 8'h00);
    `CHK("accum", 8'hB4, accum)
    check_cycle(14'h3033, 2'b11, 1'b0, 1'b0, 8'h00);
    `CHK("accum", 8'h00, accum)
    $display("test_bit_skip done");
  endtask
  task automatic test_dont_care_goto;
    check_cycle(14'h017F, 2'b00, 1'b0, 1'b0, 8'h00);
    `CHK("accum", 8'h33, accum)
    check_cycle(14'h280C, 2'b10, 1'b0, 1'b0, 8'h00);
    `CHK("accum", 8'h00, accum)
    `CHK("flag_z", 1'b1, flag_z)
    check_cycle(14'h0000, 2'b00, 1'b1, 1'b0, 8'h00);
    `CHK("prog_addr", 13'h000C, prog_addr)
    check_cycle(14'h280C, 2'b10, 1'b0, 1'b0, 8'h00);
    $display("test_dont_care_goto done");
  endtask
  initial begin
    rst_b = 1'b0;
    for (int i = 0; i < 13; i++) begin
      u_iwd_prog_mem.mem[i] = prog_image[i];
    end
    test_reset();
    test_byte_ops();
    test_bit_skip();
    test_dont_care_goto();
    complete_run();
  end
  initial begin
    #(25 * 400);
    err_count++;
    complete_run();
  end
endmodule
bind iwd_core iwd_core_assertions #(.PC_W(PC_W), .FILE_AW(FILE_AW)) u_iwd_core_assertions (.mclk(mclk),
  .rst_b(rst_b), .prog_addr(prog_addr), .exec_word(exec_word), .instr_class(instr_class), .q_phase(q_phase),
  .idle_slot(idle_slot), .retire(retire), .file_wr(file_wr), .file_addr(file_addr));
